// >>> pefao_pkg.sv
// Constants for the port E/F pin override block: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package pefao_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PEFAO_E_LATCH_ADDR = 8'h00;
  localparam logic [7:0] PEFAO_E_DIR_ADDR   = 8'h04;
  localparam logic [7:0] PEFAO_E_PIN_ADDR   = 8'h08;
  localparam logic [7:0] PEFAO_F_LATCH_ADDR = 8'h0C;
  localparam logic [7:0] PEFAO_F_DIR_ADDR   = 8'h10;
  localparam logic [7:0] PEFAO_F_PIN_ADDR   = 8'h14;
  localparam logic [7:0] PEFAO_CTRL_ADDR    = 8'h18;
  localparam logic [7:0] PEFAO_PCMASK_ADDR  = 8'h1C;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int PEFAO_CTRL_RECV_EN  = 0;
  localparam int PEFAO_CTRL_XMIT_EN  = 1;
  localparam int PEFAO_CTRL_PULL_DIS = 2;
  localparam int PEFAO_CTRL_PCGE    = 3;
  localparam int PEFAO_CTRL_SYNC    = 4;
  localparam int PEFAO_CTRL_TWO     = 5;
  localparam int PEFAO_CTRL_THREE   = 6;
  localparam int PEFAO_CTRL_AIN0D   = 7;
  localparam int PEFAO_CTRL_AIN1D   = 8;
  localparam int PEFAO_CTRL_W       = 9;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0]            PEFAO_PORT_RST = 8'h00;
  localparam logic [PEFAO_CTRL_W-1:0] PEFAO_CTRL_RST = 9'h000;
  localparam logic [1:0]            PEFAO_RESP_OKAY   = 2'h0;
  localparam logic [1:0]            PEFAO_RESP_SLVERR = 2'h2;

endpackage

// >>> pefao_top.sv
// Pin override logic for two 8-bit ports (E and F) with an AXI4-Lite register slave.
// Assumes pin inputs synchronous to aclk; the TAP controller and peripherals live outside.
`timescale 1ns/100ps
module pefao_top
  import pefao_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        clock_output_fuse,
  input  wire logic        io_clock,
  input  wire logic        test_port_enable,
  input  wire logic        tap_shift_ir,
  input  wire logic        tap_shift_dr,
  input  wire logic        tap_tdo,
  input  wire logic        txd_data,
  input  wire logic        serial_external_clock_data,
  input  wire logic        usi_do,
  input  wire logic        usi_sda_data,
  input  wire logic        usi_scl_hold,
  input  wire logic        usi_start_int_en,
  input  wire logic [7:0]  pe_in,
  output logic [7:0]       pe_out,
  output logic [7:0]       pe_oe,
  output logic [7:0]       pe_pullup,
  input  wire logic [7:0]  pf_in,
  output logic [7:0]       pf_out,
  output logic [7:0]       pf_oe,
  output logic [7:0]       pf_pullup,
  output logic [7:0]       pe_din,
  output logic [7:0]       pf_din,
  output logic             tap_tdi,
  output logic             tap_tms,
  output logic             tap_tck
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]              e_latch_q, e_latch_d, e_dir_q, e_dir_d;
  logic [7:0]              f_latch_q, f_latch_d, f_dir_q, f_dir_d;
  logic [PEFAO_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [7:0]              pcmask_q, pcmask_d;
  logic [7:0]              pe_din_d, pf_din_d, pe_din_q, pf_din_q;
  logic                    aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0]              awaddr_q, awaddr_d;
  logic [31:0]             wdata_q, wdata_d;
  logic                    wstrb0_q, wstrb0_d;
  logic                    bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]              bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    do_write;

  logic receiver_enable, transmitter_enable, global_pullup_disable, pin_change_group_enable;
  logic sync_serial_mode, universal_serial_two_wire_mode, usi_three_wire;
  assign receiver_enable                = ctrl_q[PEFAO_CTRL_RECV_EN];
  assign transmitter_enable             = ctrl_q[PEFAO_CTRL_XMIT_EN];
  assign global_pullup_disable          = ctrl_q[PEFAO_CTRL_PULL_DIS];
  assign pin_change_group_enable        = ctrl_q[PEFAO_CTRL_PCGE];
  assign sync_serial_mode               = ctrl_q[PEFAO_CTRL_SYNC];
  assign universal_serial_two_wire_mode = ctrl_q[PEFAO_CTRL_TWO];
  assign usi_three_wire                 = ctrl_q[PEFAO_CTRL_THREE];

  // ----------------------------------------------------------------
  // Override vectors
  // ----------------------------------------------------------------
  // Pull-up, direction, value and digital-input override enables/values per pin
  logic [7:0] e_puoe, e_puov, e_ddoe, e_ddov, e_pvoe, e_pvov, e_dieoe, e_dieov;
  logic [7:0] f_puoe, f_puov, f_ddoe, f_ddov, f_pvoe, f_pvov, f_dieoe, f_dieov;
  logic [7:0] pc_en;
  logic       clk_pin_take, serial_clock_drive;

  always_comb begin
    pc_en        = pcmask_q & {8{pin_change_group_enable}};
    // Reset is sampled as a level here so the clock leaves on bit 7 while reset is held
    clk_pin_take = clock_output_fuse | ~aresetn;
    serial_clock_drive = sync_serial_mode & e_dir_q[2];
    e_puoe  = {2'b00, universal_serial_two_wire_mode, 2'b00, serial_clock_drive, transmitter_enable, receiver_enable};
    e_puov  = {7'h00, e_latch_q[0]};
    e_ddoe  = {clk_pin_take, 1'b0, universal_serial_two_wire_mode, universal_serial_two_wire_mode,
               2'b00, transmitter_enable, receiver_enable};
    e_ddov  = {1'b1, 1'b0, (usi_sda_data | e_latch_q[5]) & e_dir_q[5],
               usi_scl_hold | e_latch_q[4] | e_dir_q[4], 2'b00, 1'b1, 1'b0};
    e_pvoe  = {clk_pin_take, usi_three_wire, universal_serial_two_wire_mode & e_dir_q[5],
               universal_serial_two_wire_mode & e_dir_q[4], 1'b0, serial_clock_drive, transmitter_enable, 1'b0};
    e_pvov  = {io_clock, usi_do, 3'b000, serial_external_clock_data, txd_data, 1'b0};
    e_dieoe = pc_en | {2'b00, {2{usi_start_int_en}}, ctrl_q[PEFAO_CTRL_AIN1D], ctrl_q[PEFAO_CTRL_AIN0D], 2'b00};
    e_dieov = {4'hF, pc_en[3], pc_en[2], 2'b11};
    // Test port claims the upper four analog pins
    f_puoe  = {{4{test_port_enable}}, 4'h0};
    f_puov  = 8'hF0;
    f_ddoe  = {{4{test_port_enable}}, 4'h0};
    f_ddov  = {1'b0, tap_shift_ir | tap_shift_dr, 6'h00};
    f_pvoe  = {1'b0, test_port_enable, 6'h00};
    f_pvov  = {1'b0, tap_tdo, 6'h00};
    f_dieoe = {{4{test_port_enable}}, 4'h0};
    f_dieov = 8'h00;
  end

  // Per pin, an override enable picks its value over the port register setting
  logic [7:0] e_die, f_die;
  always_comb begin
    pe_oe     = (e_ddoe & e_ddov) | (~e_ddoe & e_dir_q);
    pe_out    = (e_pvoe & e_pvov) | (~e_pvoe & e_latch_q);
    pe_pullup = (e_puoe & e_puov) | (~e_puoe & e_latch_q & ~e_dir_q & {8{~global_pullup_disable}});
    e_die     = e_dieov | ~e_dieoe;
    pf_oe     = (f_ddoe & f_ddov) | (~f_ddoe & f_dir_q);
    pf_out    = (f_pvoe & f_pvov) | (~f_pvoe & f_latch_q);
    // Override is combinational so the test pull-ups survive register reset
    pf_pullup = (f_puoe & f_puov) | (~f_puoe & f_latch_q & ~f_dir_q & {8{~global_pullup_disable}});
    f_die     = f_dieov | ~f_dieoe;
  end

  // Test pins bypass the digital input gate; the TAP runs on tap_tck itself
  assign tap_tdi = test_port_enable & pf_in[7];
  assign tap_tms = test_port_enable & pf_in[5];
  assign tap_tck = test_port_enable & pf_in[4];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign pe_din        = pe_din_q;
  assign pf_din        = pf_din_q;

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    e_latch_d = e_latch_q;
    e_dir_d   = e_dir_q;
    f_latch_d = f_latch_q;
    f_dir_d   = f_dir_q;
    ctrl_d    = ctrl_q;
    pcmask_d  = pcmask_q;
    // Pins read as zero where digital input is disabled, saving a floating input
    pe_din_d  = pe_in & e_die;
    pf_din_d  = pf_in & f_die;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    do_write = aw_full_q & w_full_q & ~bvalid_q;
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = PEFAO_RESP_OKAY;
      case (awaddr_q)
        PEFAO_E_LATCH_ADDR: if (wstrb0_q) e_latch_d = wdata_q[7:0];
        PEFAO_E_DIR_ADDR:   if (wstrb0_q) e_dir_d = wdata_q[7:0];
        PEFAO_F_LATCH_ADDR: if (wstrb0_q) f_latch_d = wdata_q[7:0];
        PEFAO_F_DIR_ADDR:   if (wstrb0_q) f_dir_d = wdata_q[7:0];
        PEFAO_CTRL_ADDR:    if (wstrb0_q) ctrl_d = wdata_q[PEFAO_CTRL_W-1:0];
        PEFAO_PCMASK_ADDR:  if (wstrb0_q) pcmask_d = wdata_q[7:0];
        PEFAO_E_PIN_ADDR, PEFAO_F_PIN_ADDR: bresp_d = PEFAO_RESP_OKAY;
        default:            bresp_d = PEFAO_RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = PEFAO_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        PEFAO_E_LATCH_ADDR: rdata_d[7:0] = e_latch_q;
        PEFAO_E_DIR_ADDR:   rdata_d[7:0] = e_dir_q;
        PEFAO_E_PIN_ADDR:   rdata_d[7:0] = pe_din_q;
        PEFAO_F_LATCH_ADDR: rdata_d[7:0] = f_latch_q;
        PEFAO_F_DIR_ADDR:   rdata_d[7:0] = f_dir_q;
        PEFAO_F_PIN_ADDR:   rdata_d[7:0] = pf_din_q;
        PEFAO_CTRL_ADDR:    rdata_d[PEFAO_CTRL_W-1:0] = ctrl_q;
        PEFAO_PCMASK_ADDR:  rdata_d[7:0] = pcmask_q;
        default:            rresp_d = PEFAO_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q  <= 1'b0;
      w_full_q   <= 1'b0;
      awaddr_q   <= 8'h00;
      wdata_q    <= 32'h0000_0000;
      wstrb0_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= PEFAO_RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= PEFAO_RESP_OKAY;
      rdata_q    <= 32'h0000_0000;
      e_latch_q  <= PEFAO_PORT_RST;
      e_dir_q    <= PEFAO_PORT_RST;
      f_latch_q  <= PEFAO_PORT_RST;
      f_dir_q    <= PEFAO_PORT_RST;
      ctrl_q     <= PEFAO_CTRL_RST;
      pcmask_q   <= PEFAO_PORT_RST;
      pe_din_q   <= PEFAO_PORT_RST;
      pf_din_q   <= PEFAO_PORT_RST;
    end else begin
      aw_full_q  <= aw_full_d;
      w_full_q   <= w_full_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb0_q   <= wstrb0_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      e_latch_q  <= e_latch_d;
      e_dir_q    <= e_dir_d;
      f_latch_q  <= f_latch_d;
      f_dir_q    <= f_dir_d;
      ctrl_q     <= ctrl_d;
      pcmask_q   <= pcmask_d;
      pe_din_q   <= pe_din_d;
      pf_din_q   <= pf_din_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rx_input: assert property (@(posedge aclk) disable iff (!aresetn)
    receiver_enable |-> !pe_oe[0]) else $error("receive pin driven while receiver on");
  a_rx_pullup: assert property (@(posedge aclk) disable iff (!aresetn)
    receiver_enable |-> pe_pullup[0] == e_latch_q[0]) else $error("receive pin pull-up wrong");
  a_clk_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    clock_output_fuse |-> pe_oe[7] && pe_out[7] == io_clock) else $error("clock pin not driven");
  a_jtag_pullups: assert property (@(posedge aclk) disable iff (1'b0)
    test_port_enable |-> pf_pullup[7] && pf_pullup[5] && pf_pullup[4]) else $error("test pull-ups off");
  a_jtag_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    test_port_enable ##1 test_port_enable |-> pf_din[7:4] == 4'h0 && !pf_oe[7] && !pf_oe[5])
    else $error("test pins usable as I/O");
  a_tdo_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    test_port_enable && !tap_shift_ir && !tap_shift_dr |-> !pf_oe[6] && pf_pullup[6])
    else $error("test data out driven outside shift");
  a_tdi_route: assert property (@(posedge aclk) disable iff (!aresetn)
    test_port_enable |-> tap_tdi == pf_in[7] && tap_tck == pf_in[4]) else $error("test pins not routed");
  a_clk_reset: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |-> pe_oe[7] && pe_out[7] == io_clock) else $error("clock pin idle in reset");
  a_serial_clock_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    !sync_serial_mode && !clock_output_fuse |-> pe_out[2] == e_latch_q[2]) else $error("serial clock active");
  a_plain_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_q == PEFAO_E_DIR_ADDR && wstrb0_q |=> pe_oe[3] == $past(wdata_q[3]))
    else $error("direction not applied");

endmodule

// >>> pefao_pin_model.sv
// Board side of ports E and F: resolves each pad from design drive, board drive and pull-up.
// Assumes the bench supplies board values; an undriven pad without pull-up wanders every cycle.
`timescale 1ns/100ps
module pefao_pin_model (
  input  wire logic        aclk,
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [15:0] pad_pu,
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [15:0] pad_in
);
  logic [15:0] float_q = 16'h0000;

  // Floating pads toggle so a lost pull-up cannot hide behind a lucky settle
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // No converter here, so analog outputs never switch mid-conversion
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pu[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

// >>> tb_pefao_top.sv
// Self-checking bench for the port E/F pin override block with a reference model of the pads.
// Assumes pefao_pkg, pefao_top and pefao_pin_model are compiled first.
`timescale 1ns/100ps
module tb_pefao_top;
  import pefao_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, rv, d;
  logic        clock_output_fuse = 1'b0, io_clock = 1'b0, test_port_enable = 1'b1;
  logic        tap_shift_ir = 1'b0, tap_shift_dr = 1'b0, tap_tdo = 1'b0, txd_data = 1'b0;
  logic        serial_external_clock_data = 1'b0;
  logic        usi_do = 1'b0, usi_sda_data = 1'b0, usi_scl_hold = 1'b0, usi_start_int_en = 1'b0;
  logic [7:0]  pe_in, pe_out, pe_oe, pe_pullup, pf_in, pf_out, pf_oe, pf_pullup, pe_din, pf_din;
  logic        tap_tdi, tap_tms, tap_tck;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] ext_en = 16'hFFFF;
  logic [7:0]  exp_e_pin, exp_e_mask, exp_f_pin, exp_f_mask;
  logic [7:0]  reg_a [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C};
  int          failures = 0;
  int          n_tests = 0;
  int          e_lat = 0, e_dir = 0, f_lat = 0, f_dir = 0, ctrl = 0, pc_mask = 0;

  initial begin
    forever #25 aclk = ~aclk;
  end

  pefao_top u_pefao_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clock_output_fuse, .io_clock, .test_port_enable, .tap_shift_ir, .tap_shift_dr, .tap_tdo,
    .txd_data, .serial_external_clock_data, .usi_do, .usi_sda_data, .usi_scl_hold, .usi_start_int_en,
    .pe_in, .pe_out, .pe_oe, .pe_pullup, .pf_in, .pf_out, .pf_oe, .pf_pullup, .pe_din, .pf_din,
    .tap_tdi, .tap_tms, .tap_tck
  );

  pefao_pin_model u_pefao_pin_model (
    .aclk, .pad_out({pf_out, pe_out}), .pad_oe({pf_oe, pe_oe}), .pad_pu({pf_pullup, pe_pullup}),
    .ext_val, .ext_en, .pad_in({pf_in, pe_in})
  );

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timed_out();
    failures++;
    $display("unexpected at %0t: bus answer never came", $time);
    test_done();
  endtask

  // Sampling at the falling edge sees what the next rising edge will take
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    logic aw_hit, w_hit, b_hit;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i <= 60; i++) begin
      if (i == 60) timed_out();
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit  = s_axi_wvalid && s_axi_wready;
      b_hit  = s_axi_bvalid;
      resp   = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic ar_hit, r_hit;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i <= 60; i++) begin
      if (i == 60) timed_out();
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit  = s_axi_rvalid;
      dat    = s_axi_rdata;
      resp   = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic check_pins();
    logic [7:0] eo, ev, ep, fo, fv, fp, pin_e, pin_f, dis_e, me, mf;
    eo    = e_dir[7:0];
    ev    = e_lat[7:0];
    ep    = e_lat[7:0] & ~e_dir[7:0] & {8{!ctrl[PEFAO_CTRL_PULL_DIS]}};
    fo    = f_dir[7:0];
    fv    = f_lat[7:0];
    fp    = f_lat[7:0] & ~f_dir[7:0] & {8{!ctrl[PEFAO_CTRL_PULL_DIS]}};
    dis_e = 8'h00;
    if (ctrl[PEFAO_CTRL_SYNC] && e_dir[2]) begin
      {ev[2], ep[2]} = {serial_external_clock_data, 1'b0};
    end
    if (ctrl[PEFAO_CTRL_XMIT_EN]) begin
      {eo[1], ev[1], ep[1]} = {1'b1, txd_data, 1'b0};
    end
    if (ctrl[PEFAO_CTRL_RECV_EN]) begin
      {eo[0], ep[0]} = {1'b0, e_lat[0]};
    end
    if (ctrl[PEFAO_CTRL_THREE]) begin
      ev[6] = usi_do;
    end
    // Two-wire mode: data pin drives low only, clock pin held by the serial unit
    if (ctrl[PEFAO_CTRL_TWO]) begin
      eo[5:4] = {(usi_sda_data | e_lat[5]) & e_dir[5], usi_scl_hold | e_lat[4] | e_dir[4]};
      ev[5:4] = ev[5:4] & ~e_dir[5:4];
      ep[5]   = 1'b0;
    end
    if (clock_output_fuse) begin
      {eo[7], ev[7]} = {1'b1, io_clock};
    end
    if (test_port_enable) begin
      fo[7:4] = {1'b0, tap_shift_ir | tap_shift_dr, 2'b00};
      fv[6]   = tap_tdo;
      fp[7:4] = 4'hF;
    end
    dis_e[3] = ctrl[PEFAO_CTRL_AIN1D] && !(pc_mask[3] && ctrl[PEFAO_CTRL_PCGE]);
    dis_e[2] = ctrl[PEFAO_CTRL_AIN0D] && !(pc_mask[2] && ctrl[PEFAO_CTRL_PCGE]);
    pin_e = (eo & ev) | (~eo & ((ext_en[7:0] & ext_val[7:0]) | ~ext_en[7:0]));
    pin_f = (fo & fv) | (~fo & ((ext_en[15:8] & ext_val[15:8]) | ~ext_en[15:8]));
    me    = eo | ext_en[7:0] | ep;
    mf    = fo | ext_en[15:8] | fp;
    exp_e_pin  = pin_e & ~dis_e;
    exp_e_mask = me;
    exp_f_pin  = pin_f & {~{4{test_port_enable}}, 4'hF};
    exp_f_mask = mf;
    check(pe_oe, eo, "port E direction");
    check(pe_out & eo, ev & eo, "port E value");
    check(pe_pullup & {~clock_output_fuse, 7'h7F}, ep & {~clock_output_fuse, 7'h7F}, "E pull");
    check(pf_oe, fo, "port F direction");
    check(pf_out & fo, fv & fo, "port F value");
    check(pf_pullup, fp, "port F pull-up");
    check(pe_din & me, pin_e & ~dis_e & me, "port E input");
    check(pf_din & mf, pin_f & {~{4{test_port_enable}}, 4'hF} & mf, "port F input");
    if (test_port_enable) check({tap_tdi, tap_tms, tap_tck}, {pin_f[7], pin_f[5], pin_f[4]}, "tap");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(57));
    for (int k = 0; k < 2; k++) begin
      io_clock <= k[0];
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      check({pe_oe[7], pe_out[7]}, {1'b1, k[0]}, "clock pin in reset");
      check(pf_pullup[7:4], 4'hF, "tap pull-ups in reset");
    end
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    $display("test reset done");
    foreach (reg_a[i]) begin
      rd(reg_a[i], d, r);
      check(d, 32'h0000_0000, "register reset value");
      check(r, PEFAO_RESP_OKAY, "read response");
    end
    rd(8'h20, d, r);
    check({d[29:0], r}, {30'h0000_0000, PEFAO_RESP_SLVERR}, "unmapped read");
    wr(8'h20, 32'h0000_00FF, r);
    check(r, PEFAO_RESP_SLVERR, "unmapped write");
    wr(PEFAO_E_PIN_ADDR, 32'h0000_00FF, r);
    check(r, PEFAO_RESP_OKAY, "pin register write");
    s_axi_wstrb <= 4'hE;
    wr(PEFAO_E_LATCH_ADDR, 32'h0000_00A5, r);
    s_axi_wstrb <= 4'hF;
    rd(PEFAO_E_LATCH_ADDR, d, r);
    check(d, 32'h0000_0000, "masked write ignored");
    $display("test registers done");
    for (int t = 0; t < 40; t++) begin
      e_lat   = $urandom & 32'hFF;
      e_dir   = $urandom & 32'hFF;
      f_lat   = $urandom & 32'hFF;
      f_dir   = $urandom & 32'hFF;
      pc_mask = $urandom & 32'hFF;
      ctrl    = $urandom & 32'h1FF;
      wr(PEFAO_E_LATCH_ADDR, e_lat, r);
      wr(PEFAO_E_DIR_ADDR, e_dir, r);
      wr(PEFAO_F_LATCH_ADDR, f_lat, r);
      wr(PEFAO_F_DIR_ADDR, f_dir, r);
      wr(PEFAO_PCMASK_ADDR, pc_mask, r);
      wr(PEFAO_CTRL_ADDR, ctrl, r);
      check(r, PEFAO_RESP_OKAY, "write response");
      rd(PEFAO_CTRL_ADDR, d, r);
      check(d, ctrl, "control readback");
      rv = $urandom;
      {clock_output_fuse, io_clock, test_port_enable, tap_shift_ir, tap_shift_dr, tap_tdo, txd_data,
       serial_external_clock_data, usi_do, usi_sda_data, usi_scl_hold, usi_start_int_en} <= rv[11:0];
      ext_val <= rv[31:16];
      rv = $urandom;
      ext_en <= rv[15:0] | rv[31:16];
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      check_pins();
      @(posedge aclk);
      rd(PEFAO_E_PIN_ADDR, d, r);
      check(d & {24'hFF_FFFF, exp_e_mask}, {24'h00_0000, exp_e_pin & exp_e_mask}, "E pin read");
      rd(PEFAO_F_PIN_ADDR, d, r);
      check(d & {24'hFF_FFFF, exp_f_mask}, {24'h00_0000, exp_f_pin & exp_f_mask}, "F pin read");
    end
    $display("test random overrides done");
    test_done();
  end
endmodule
